// >>> grc_remote_local_clear.sv
`timescale 1ns/1ps
`default_nettype none

module grc_remote_local_clear #(
    parameter int MEM_DEPTH = 128,
    parameter int MEM_AW    = $clog2(MEM_DEPTH)
) (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic                        ce,
    input  wire grc_pkg::grc_pins_t          busPins,
    input  wire logic                        selfTestDone,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [grc_pkg::APB_AW-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic                             pready,
    output logic      [31:0]                 prdata,
    output logic                             pslverr,
    output grc_pkg::grc_panel_t              panel,
    output logic                             panelLocked,
    output logic                             outputOn,
    output logic      [1:0]                  dispSel,
    output logic      [1:0]                  progMode,
    output logic      [7:0]                  bufPtr,
    output logic      [7:0]                  dispPtr,
    output logic                             selfTestFlag,
    output logic                             triggerPulse,
    output logic                             deviceClear,
    output logic                             memWipeWe,
    output logic      [MEM_AW-1:0]           memWipeAddr,
    output logic                             memWipeBusy
);
    import grc_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    grc_pins_t  pinSync;
    grc_state_t state;
    grc_state_t next_state;

    // Every bus line crosses in from the cable
    grc_sync #(
        .W       ($bits(grc_pins_t)),
        .RST_VAL (PINS_IDLE)
    ) uPinSync (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .din     (busPins),
        .dout    (pinSync)
    );

    // ****************************************
    // Command decode
    // ****************************************
    logic     atnAct, renAct, ifcAct, davAct;
    grc_cmd_t cmdByte;
    logic     cmdStrobe, isMyListen, isMyTalk, isOtherTalk, isUnl;
    logic     isGtl, isSdc, isGet, isLlo, isDcl;
    logic     addressedCmd, clrNow;

    // Lines are negative true; DIO8 is ignored
    assign atnAct  = !pinSync.atnN;
    assign renAct  = !pinSync.renN;
    assign ifcAct  = !pinSync.ifcN;
    assign davAct  = !pinSync.davN;
    assign cmdByte = grc_cmd_t'(~pinSync.dioN);

    // One command per data-valid leading edge under ATN
    assign cmdStrobe = ce && atnAct && davAct && !state.davPrev;

    assign isMyListen  = (cmdByte.grp == GRP_LISTEN) && (cmdByte.addr == state.primaryAddr)
                         && (cmdByte.addr != ADDR_UNADDR);
    assign isMyTalk    = (cmdByte.grp == GRP_TALK) && (cmdByte.addr == state.primaryAddr)
                         && (cmdByte.addr != ADDR_UNADDR);
    assign isOtherTalk = (cmdByte.grp == GRP_TALK) && !isMyTalk;
    assign isUnl       = (cmdByte.grp == GRP_LISTEN) && (cmdByte.addr == ADDR_UNADDR);

    assign isLlo = ({cmdByte.grp, cmdByte.addr} == CMD_LLO);
    assign isDcl = ({cmdByte.grp, cmdByte.addr} == CMD_DCL);
    assign isGtl = ({cmdByte.grp, cmdByte.addr} == CMD_GTL);
    assign isSdc = ({cmdByte.grp, cmdByte.addr} == CMD_SDC);
    assign isGet = ({cmdByte.grp, cmdByte.addr} == CMD_GET);

    assign addressedCmd = cmdStrobe &&
                          (isMyListen || (state.listen && (isGtl || isSdc || isGet)));

    assign clrNow = cmdStrobe && (isDcl || (isSdc && state.listen));

    // ****************************************
    // APB slave
    // ****************************************
    logic                   apbSetup, apbWrite;
    wire grc_ctrl_reg_t     wrCtrl     = pwdata;
    wire grc_selftest_reg_t wrSelfTest = pwdata;

    // Read data is latched in setup, so no wait states
    assign apbSetup = psel && !penable;
    assign pready   = psel && penable;
    assign apbWrite = pready && pwrite && !state.slvErr;
    assign pslverr  = pready && state.slvErr;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_state            = state;
        next_state.davPrev    = davAct;
        next_state.trigger    = 1'b0;
        next_state.clearPulse = 1'b0;

        // Listener and talker addressing
        if (cmdStrobe) begin
            if (isMyListen) begin
                next_state.listen = 1'b1;
                next_state.talk   = 1'b0;
            end else if (isMyTalk) begin
                next_state.talk   = 1'b1;
                next_state.listen = 1'b0;
            end else if (isOtherTalk) begin
                next_state.talk = 1'b0;
            end else if (isUnl) begin
                next_state.listen = 1'b0;
            end
        end

        if (renAct && addressedCmd) begin
            next_state.remote = 1'b1;
        end

        if (cmdStrobe && isGtl && state.listen) begin
            next_state.remote = 1'b0;
        end

        if (cmdStrobe && isLlo && renAct) begin
            next_state.lockout = 1'b1;
        end

        if (!renAct) begin
            next_state.remote  = 1'b0;
            next_state.lockout = 1'b0;
        end

        if (ifcAct) begin
            next_state.talk   = 1'b0;
            next_state.listen = 1'b0;
        end

        next_state.trigger = cmdStrobe && isGet;

        // Read mux, also flags unmapped addresses
        if (apbSetup) begin
            next_state.slvErr = 1'b0;
            case (paddr)
                REG_CTRL: begin
                    next_state.rdData = grc_ctrl_reg_t'{rsvd: '0, primaryAddr: state.primaryAddr};
                end
                REG_STATUS: begin
                    next_state.rdData = grc_status_reg_t'{rsvd: '0, ren: renAct,
                        wipeBusy: memWipeBusy, listen: state.listen, talk: state.talk,
                        lockout: state.lockout, remote: state.remote};
                end
                REG_MODE: begin
                    next_state.rdData = state.mode;
                end
                REG_PTR: begin
                    next_state.rdData = state.ptr;
                end
                REG_SELFTEST: begin
                    next_state.rdData = grc_selftest_reg_t'{rsvd: '0, selfTest: state.selfTest};
                end
                default: begin
                    next_state.rdData = '0;
                    next_state.slvErr = 1'b1;
                end
            endcase
        end

        // Register writes at the access edge
        if (apbWrite) begin
            case (paddr)
                REG_CTRL: begin
                    next_state.primaryAddr = wrCtrl.primaryAddr;
                end
                REG_MODE: begin
                    next_state.mode      = grc_mode_reg_t'(pwdata);
                    next_state.mode.rsvd = '0;
                end
                REG_PTR: begin
                    next_state.ptr      = grc_ptr_reg_t'(pwdata);
                    next_state.ptr.rsvd = '0;
                end
                REG_SELFTEST: begin
                    if (wrSelfTest.selfTest) begin
                        next_state.selfTest = 1'b0;
                    end
                end
                default: begin
                    next_state.slvErr = state.slvErr;
                end
            endcase
        end

        // only self test or power up sets it
        if (selfTestDone) begin
            next_state.selfTest = 1'b1;
        end

        // Power-up state, then shared defaults
        if (!reset_n) begin
            next_state             = '0;
            next_state.primaryAddr = ADDR_RST;
            next_state.selfTest    = 1'b1;
        end

        // output off, source, step
        // A clear beats a software write in the same cycle
        if (clrNow || !reset_n) begin
            next_state.mode.outputOn = 1'b0;
            next_state.mode.dispSel  = DISP_SOURCE;
            next_state.mode.progMode = PROG_STEP;
            next_state.ptr.bufPtr    = PTR_HOME;
            next_state.ptr.dispPtr   = PTR_HOME;
        end
        next_state.clearPulse = clrNow && reset_n;
    end

    // Single state register, frozen by the clock enable
    always_ff @(posedge clk) begin
        if (!reset_n || ce) begin
            state <= next_state;
        end
    end

    // ****************************************
    // Program memory erase
    // ****************************************
    // wipe every stored program word
    grc_mem_wipe #(
        .DEPTH   (MEM_DEPTH),
        .AW      (MEM_AW)
    ) uWipe (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .start   (state.clearPulse),
        .busy    (memWipeBusy),
        .we      (memWipeWe),
        .addr    (memWipeAddr)
    );

    // ****************************************
    // Outputs
    // ****************************************
    // one flag per panel light
    assign panel.remoteLed  = state.remote;
    assign panel.lockoutLed = state.lockout;
    assign panel.talkLed    = state.talk;
    assign panel.listenLed  = state.listen;
    assign panelLocked      = state.lockout;
    assign outputOn         = state.mode.outputOn;
    assign dispSel          = state.mode.dispSel;
    assign progMode         = state.mode.progMode;
    assign bufPtr           = state.ptr.bufPtr;
    assign dispPtr          = state.ptr.dispPtr;
    assign selfTestFlag     = state.selfTest;
    assign triggerPulse     = state.trigger;
    assign deviceClear      = state.clearPulse;
    assign prdata           = state.rdData;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cbMain @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence sqSdcStranger;
        cmdStrobe && isSdc && !state.listen;
    endsequence
    sequence sqLloWithRen;
        cmdStrobe && isLlo && renAct;
    endsequence
    sequence sqGtlLocked;
        cmdStrobe && isGtl && state.listen && renAct && state.lockout;
    endsequence
    sequence sqClearSeen;
        ce && state.clearPulse;
    endsequence

    AST_SDC_NEEDS_ADDR: assert property (sqSdcStranger |=> !state.clearPulse)
        else $error("SDC acted on without listen address");
    AST_DCL_UNADDR: assert property (cmdStrobe && isDcl |=> state.clearPulse)
        else $error("DCL ignored");
    AST_REN_ALONE: assert property (ce && !cmdStrobe && !state.remote |=> !state.remote)
        else $error("Remote entered without a command");
    AST_REMOTE_ON: assert property (renAct && cmdStrobe && isMyListen
                                    |=> state.remote && panel.remoteLed)
        else $error("Remote not entered on listen address");
    AST_IFC_IDLE: assert property (ce && ifcAct && renAct && !cmdStrobe
                                   |=> !state.talk && !state.listen && $stable(state.remote)
                                       && $stable(state.lockout))
        else $error("IFC did not idle or changed other state");
    AST_LLO_LOCKS: assert property (sqLloWithRen |=> state.lockout && panelLocked)
        else $error("Lockout not taken");
    AST_LLO_NO_REN: assert property (cmdStrobe && isLlo && !renAct |=> !state.lockout)
        else $error("Lockout without REN");
    AST_GTL_KEEPS_LOCK: assert property (sqGtlLocked |=> !state.remote && state.lockout)
        else $error("GTL handling wrong");
    AST_REN_FALSE: assert property (ce && !renAct |=> !state.remote && !state.lockout)
        else $error("REN false left remote or lockout");
    AST_CLEAR_DEFAULTS: assert property (state.clearPulse
                                         |-> bufPtr == PTR_HOME && dispPtr == PTR_HOME
                                             && !outputOn && dispSel == DISP_SOURCE
                                             && progMode == PROG_STEP)
        else $error("Clear did not restore defaults");
    AST_CLEAR_WIPES: assert property (sqClearSeen |=> memWipeBusy && memWipeAddr == '0)
        else $error("Memory wipe did not start");
    AST_GET_ANY: assert property (cmdStrobe && isGet |=> triggerPulse)
        else $error("GET not accepted");
    AST_SDC_LISTENER: assert property (cmdStrobe && isSdc && state.listen
                                       |=> state.clearPulse)
        else $error("SDC as listener ignored");
    AST_SELFTEST_KEEP: assert property (ce && clrNow && !selfTestDone && !apbWrite
                                        |=> $stable(state.selfTest))
        else $error("Clear touched the self test flag");

endmodule : grc_remote_local_clear

`default_nettype wire

// >>> grc_pkg.sv
package grc_pkg;

    // ****************************************
    // Bus command codes, seven bit, positive
    // ****************************************
    localparam logic [6:0] CMD_GTL     = 7'h01;
    localparam logic [6:0] CMD_SDC     = 7'h04;
    localparam logic [6:0] CMD_GET     = 7'h08;
    localparam logic [6:0] CMD_LLO     = 7'h11;
    localparam logic [6:0] CMD_DCL     = 7'h14;
    localparam logic [1:0] GRP_LISTEN  = 2'h1;
    localparam logic [1:0] GRP_TALK    = 2'h2;
    localparam logic [4:0] ADDR_UNADDR = 5'h1f;
    localparam logic [4:0] ADDR_RST    = 5'h0c;

    // ****************************************
    // Register map and reset values
    // ****************************************
    localparam int          APB_AW       = 12;
    localparam logic [11:0] REG_CTRL     = 12'h000;
    localparam logic [11:0] REG_STATUS   = 12'h004;
    localparam logic [11:0] REG_MODE     = 12'h008;
    localparam logic [11:0] REG_PTR      = 12'h00c;
    localparam logic [11:0] REG_SELFTEST = 12'h010;
    localparam logic [1:0]  DISP_SOURCE  = 2'h0;
    localparam logic [1:0]  PROG_STEP    = 2'h2;
    localparam logic [7:0]  PTR_HOME     = 8'h01;

    // ****************************************
    // Carriers and register layouts
    // ****************************************
    // Bus lines are negative true on the wire
    typedef struct packed {
        logic       atnN;
        logic       renN;
        logic       ifcN;
        logic       davN;
        logic [7:0] dioN;
    } grc_pins_t;
    localparam grc_pins_t PINS_IDLE = 12'hfff;

    typedef struct packed {
        logic       parity;
        logic [1:0] grp;
        logic [4:0] addr;
    } grc_cmd_t;

    typedef struct packed {
        logic remoteLed;
        logic lockoutLed;
        logic talkLed;
        logic listenLed;
    } grc_panel_t;

    typedef struct packed {
        logic [25:0] rsvd;
        logic        ren;
        logic        wipeBusy;
        logic        listen;
        logic        talk;
        logic        lockout;
        logic        remote;
    } grc_status_reg_t;

    typedef struct packed {
        logic [26:0] rsvd;
        logic [1:0]  progMode;
        logic [1:0]  dispSel;
        logic        outputOn;
    } grc_mode_reg_t;

    typedef struct packed {
        logic [15:0] rsvd;
        logic [7:0]  dispPtr;
        logic [7:0]  bufPtr;
    } grc_ptr_reg_t;

    typedef struct packed {
        logic [26:0] rsvd;
        logic [4:0]  primaryAddr;
    } grc_ctrl_reg_t;

    typedef struct packed {
        logic [30:0] rsvd;
        logic        selfTest;
    } grc_selftest_reg_t;

    typedef enum logic [1:0] {
        WIPE_IDLE = 2'b01,
        WIPE_RUN  = 2'b10
    } grc_wipe_fsm_t;

    typedef struct packed {
        logic          davPrev;
        logic          remote;
        logic          lockout;
        logic          talk;
        logic          listen;
        logic [4:0]    primaryAddr;
        grc_mode_reg_t mode;
        grc_ptr_reg_t  ptr;
        logic          selfTest;
        logic          trigger;
        logic          clearPulse;
        logic [31:0]   rdData;
        logic          slvErr;
    } grc_state_t;

endpackage : grc_pkg

// >>> grc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module grc_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    import grc_pkg::*;

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] held;
    } grc_sync_state_t;

    grc_sync_state_t state;
    grc_sync_state_t next_state;

    // Only the second stage reads the first
    always_comb begin
        next_state.meta = din;
        next_state.held = state.meta;
        if (!reset_n) begin
            next_state.meta = RST_VAL;
            next_state.held = RST_VAL;
        end
    end

    // Frozen with the clock enable, reset still acts
    always_ff @(posedge clk) begin
        if (!reset_n || ce) begin
            state <= next_state;
        end
    end

    assign dout = state.held;

endmodule : grc_sync

`default_nettype wire

// >>> grc_mem_wipe.sv
`timescale 1ns/1ps
`default_nettype none

module grc_mem_wipe #(
    parameter int DEPTH = 128,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic          clk,
    input  wire logic          reset_n,
    input  wire logic          ce,
    input  wire logic          start,
    output logic               busy,
    output logic               we,
    output logic      [AW-1:0] addr
);
    import grc_pkg::*;

    typedef struct packed {
        grc_wipe_fsm_t fsm;
        logic [AW-1:0] addr;
    } grc_wipe_state_t;

    grc_wipe_state_t state;
    grc_wipe_state_t next_state;

    // A new start restarts the sweep from the bottom
    always_comb begin
        next_state = state;
        case (state.fsm)
            WIPE_IDLE: begin
                next_state.addr = '0;
            end
            WIPE_RUN: begin
                if (state.addr == AW'(DEPTH - 1)) begin
                    next_state.fsm = WIPE_IDLE;
                end
                next_state.addr = state.addr + AW'(1);
            end
            default: begin
                next_state.fsm = WIPE_IDLE;
            end
        endcase
        if (start) begin
            next_state.fsm  = WIPE_RUN;
            next_state.addr = '0;
        end
        if (!reset_n) begin
            next_state.fsm  = WIPE_IDLE;
            next_state.addr = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || ce) begin
            state <= next_state;
        end
    end

    // One zero word written per enabled cycle
    assign busy = (state.fsm == WIPE_RUN);
    assign we   = busy;
    assign addr = state.addr;

endmodule : grc_mem_wipe

`default_nettype wire

// >>> grc_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Bus controller on the far side
// ****************************************
module grc_bus_model
    import grc_pkg::*;
(
    input  wire logic               clk,
    output var  grc_pkg::grc_pins_t pins
);
    // Lines idle high through the bus pull-ups
    initial pins = PINS_IDLE;

    task automatic setRen(input logic on);
        @(posedge clk);
        pins.renN <= ~on;
        repeat (4) @(posedge clk); // Let the synchroniser settle
    endtask : setRen

    task automatic pulseIfc();
        @(posedge clk);
        pins.ifcN <= 1'b0;
        repeat (4) @(posedge clk);
        pins.ifcN <= 1'b1;
    endtask : pulseIfc

    task automatic sendCmd(input logic [6:0] cmd);
        @(posedge clk);
        pins.atnN <= 1'b0;
        pins.dioN <= {1'b1, ~cmd};
        pins.davN <= 1'b0;
        repeat (4) @(posedge clk); // Data held past the sync delay
        pins.davN <= 1'b1;
        pins.dioN <= 8'hff;
        repeat (3) @(posedge clk);
        pins.atnN <= 1'b1;
    endtask : sendCmd
endmodule : grc_bus_model
`default_nettype wire

// >>> grc_remote_local_clear_tb.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Register bus driven sequences
// ****************************************
module grc_remote_local_clear_tb;
    import grc_pkg::*;
    logic        clk = 1'b0, resetN = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdVal;
    logic        pready, pslverr, rdErr, panelLocked, trigPulse, wipeBusy;
    grc_pins_t   busPins;
    grc_panel_t  panel;
    logic        stDone = 1'b0, outOn, stFlag, devClr, wipeWe;
    logic [1:0]  dSel, pMode, wipeAddr;
    logic [7:0]  bPtr, dPtr;
    int          errors = 0, samplesChecked = 0, trigCount = 0, wipeCycles = 0;
    int          clrCount = 0, weCount = 0, addrSum = 0;

    always #5 clk = ~clk;

    grc_bus_model MODEL (.clk(clk), .pins(busPins));
    grc_remote_local_clear #(.MEM_DEPTH(4)) DUT (
        .clk(clk), .reset_n(resetN), .ce(1'b1), .busPins(busPins), .selfTestDone(stDone),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .panel(panel),
        .panelLocked(panelLocked), .outputOn(outOn), .dispSel(dSel), .progMode(pMode),
        .bufPtr(bPtr), .dispPtr(dPtr), .selfTestFlag(stFlag), .triggerPulse(trigPulse),
        .deviceClear(devClr), .memWipeWe(wipeWe), .memWipeAddr(wipeAddr),
        .memWipeBusy(wipeBusy));

    // Pulse counters, sampled where settled
    always @(posedge clk) begin
        if (trigPulse === 1'b1) trigCount <= trigCount + 1;
        if (wipeBusy === 1'b1) wipeCycles <= wipeCycles + 1;
        if (devClr === 1'b1) clrCount <= clrCount + 1;
        if (wipeWe === 1'b1) weCount <= weCount + 1;
        if (wipeWe === 1'b1) addrSum <= addrSum + wipeAddr;
    end

    task automatic printVerdict();
        $display("Checks %0d, mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : printVerdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer, released only after pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rdVal = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            errors++;
            printVerdict();
        end
    endtask : apb

    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdVal, exp);
    endtask : rdChk

    function automatic logic [31:0] st(input logic [4:0] f);
        return {26'h0, f[4], 1'b0, f[3:0]}; // f = ren, listen, talk, lockout, remote
    endfunction : st

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        printVerdict();
    end

    initial begin
        repeat (3) @(posedge clk);
        resetN <= 1'b1;
        rdChk(REG_CTRL, 32'h0000000c);
        rdChk(REG_MODE, {27'h0, PROG_STEP, DISP_SOURCE, 1'b0});
        rdChk(REG_PTR, {16'h0, PTR_HOME, PTR_HOME});
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, rdErr}, 32'h1);
        MODEL.sendCmd(CMD_LLO);
        rdChk(REG_STATUS, st(5'b00000));
        MODEL.setRen(1'b1);
        MODEL.sendCmd(CMD_GET);
        rdChk(REG_STATUS, st(5'b10000));
        chk(trigCount, 1);
        MODEL.sendCmd({GRP_LISTEN, 5'h05});
        rdChk(REG_STATUS, st(5'b10000));
        MODEL.sendCmd({GRP_LISTEN, ADDR_RST});
        rdChk(REG_STATUS, st(5'b11001));
        MODEL.sendCmd(CMD_GET);
        chk(trigCount, 2);
        MODEL.sendCmd(CMD_LLO);
        rdChk(REG_STATUS, st(5'b11011));
        chk({panel, 3'h0, panelLocked}, 32'h000000d1);
        MODEL.sendCmd({GRP_TALK, ADDR_RST});
        rdChk(REG_STATUS, st(5'b10111));
        MODEL.pulseIfc();
        rdChk(REG_STATUS, st(5'b10011));
        MODEL.sendCmd({GRP_LISTEN, ADDR_RST});
        MODEL.sendCmd(CMD_GTL);
        rdChk(REG_STATUS, st(5'b11010));
        MODEL.setRen(1'b0);
        rdChk(REG_STATUS, st(5'b01000));
        apb(1'b1, REG_MODE, 32'h0000000f);
        MODEL.sendCmd({GRP_LISTEN, ADDR_UNADDR});
        MODEL.sendCmd(CMD_SDC);
        rdChk(REG_MODE, 32'h0000000f);
        MODEL.sendCmd({GRP_LISTEN, ADDR_RST});
        MODEL.sendCmd(CMD_SDC);
        rdChk(REG_MODE, 32'h00000010);
        apb(1'b1, REG_MODE, 32'h0000000f);
        apb(1'b1, REG_PTR, 32'h00000505);
        apb(1'b1, REG_SELFTEST, 32'h00000001);
        MODEL.sendCmd(CMD_DCL);
        rdChk(REG_MODE, 32'h00000010);
        rdChk(REG_PTR, 32'h00000101);
        rdChk(REG_SELFTEST, 32'h00000000);
        chk({outOn, dSel, pMode}, {1'b0, DISP_SOURCE, PROG_STEP});
        chk({bPtr, dPtr}, {PTR_HOME, PTR_HOME});
        chk(stFlag, 1'b0);
        chk(clrCount, 2);
        @(posedge clk);
        stDone <= 1'b1;
        @(posedge clk);
        stDone <= 1'b0;
        rdChk(REG_SELFTEST, 32'h00000001);
        chk(stFlag, 1'b1);
        repeat (20) @(posedge clk);
        chk(wipeCycles, 8); // two clears of four words
        chk(weCount, 8);
        chk(addrSum, 12); // addresses 0 to 3, twice
        printVerdict();
    end
endmodule : grc_remote_local_clear_tb
`default_nettype wire
